// File: lsds_pkg.sv
// constants for the local-oscillator synthesizer control and block standby logic
// assumes a single 25 MHz clock and register access over the serial control port
package lsds_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_STANDBY  = 7'h00;
  localparam logic [6:0] ADDR_REFDIV_H = 7'h08;
  localparam logic [6:0] ADDR_REFDIV_L = 7'h09;
  localparam logic [6:0] ADDR_SWALLOW  = 7'h0a;
  localparam logic [6:0] ADDR_CYCLES_L = 7'h0b;
  localparam logic [6:0] ADDR_PUMPCTL  = 7'h0c;
  localparam logic [6:0] ADDR_FADIV_H  = 7'h0d;
  localparam logic [6:0] ADDR_FADIV_L  = 7'h0e;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_STANDBY  = 8'hff;
  localparam logic [13:0] RST_REFDIV   = 14'h0038;
  localparam logic [2:0]  RST_SWALLOW  = 3'h5;
  localparam logic [12:0] RST_CYCLES   = 13'h001d;
  localparam logic [13:0] RST_FADIV    = 14'h0004;

  // ----------------------------------------------------------------
  // standby bit positions
  // ----------------------------------------------------------------
  localparam int SB_REF   = 7;
  localparam int SB_LO    = 6;
  localparam int SB_OSC   = 5;
  localparam int SB_CKSYN = 4;
  localparam int SB_GAIN  = 3;
  localparam int SB_FRONT = 2;
  localparam int SB_SPARE = 1;
  localparam int SB_ADC   = 0;
  // every implemented standby bit; the spare bit takes no part
  localparam logic [7:0] SB_USED_MASK = 8'hfd;

  // ----------------------------------------------------------------
  // pump control field positions
  // ----------------------------------------------------------------
  localparam int PC_FAST = 6;
  localparam int PC_INV  = 5;
  localparam int PC_CODE_LO = 2;
  localparam int PC_TM_LO   = 0;

  // ----------------------------------------------------------------
  // dividers and pump
  // ----------------------------------------------------------------
  localparam logic [3:0] PRESC_HIGH   = 4'h9;
  localparam logic [3:0] PRESC_LOW    = 4'h8;
  localparam logic [3:0] PUMP_MAX     = 4'h8;
  localparam logic [3:0] PUMP_FA_MIN  = 4'h2;
  localparam int         SPI_BITS     = 16;

  typedef enum logic [1:0] {
    LSDS_SPI_IDLE = 2'b00,
    LSDS_SPI_ADDR = 2'b01,
    LSDS_SPI_DATA = 2'b11
  } lsds_spi_e;

endpackage : lsds_pkg

// File: lsds_edge_div.sv
// programmable divider: one pulse for every divisor ticks
// assumes tick is a one-cycle pulse on clk; a divisor of zero acts as one
`timescale 1ns/1ps
module lsds_edge_div #(
  parameter int W = 14
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         en,
  input  wire logic         tick,
  input  wire logic [W-1:0] divisor,
  output logic              pulse
);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  logic         pulse_nxt;

  always_comb begin
    count_nxt = count_r;
    pulse_nxt = 1'b0;
    if (!en) begin
      count_nxt = '0;
    end else if (tick) begin
      // compare before increment so the divisor may change between pulses
      if (count_r + W'(1) >= divisor) begin
        count_nxt = '0;
        pulse_nxt = 1'b1;
      end else begin
        count_nxt = count_r + W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_r <= '0;
      pulse   <= 1'b0;
    end else begin
      count_r <= count_nxt;
      pulse   <= pulse_nxt;
    end
  end

endmodule : lsds_edge_div

// File: lsds_synth_ctrl.sv
// top of the LO synthesizer digital control with the standby register
// assumes reference, LO and serial port pins are asynchronous to clk
`timescale 1ns/1ps
module lsds_synth_ctrl #(
  parameter int REF_W = 14,
  parameter int CYC_W = 13
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       spiSclk,
  input  wire logic       spiMosi,
  input  wire logic       spiSelN,
  output logic            spiMiso,
  output logic            spiMisoOe,
  input  wire logic       refIn,
  input  wire logic       loIn,
  output logic            pumpUp,
  output logic            pumpDown,
  output logic            pumpOutputPinOe,
  output logic [3:0]      pumpSteps,
  output logic            refOff,
  output logic            loSynthOff,
  output logic            oscillatorStandby,
  output logic            samplingSynthStandby,
  output logic            gainDacStandby,
  output logic            gainDacOe,
  output logic            frontEndStandby,
  output logic            adcOff,
  output logic            filterClkRun,
  output logic            digitalHold,
  output logic            clkBufferOff,
  output logic            mainRefStandby
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [4:0] syncA_r;
  logic [4:0] syncB_r;
  logic [4:0] syncC_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      syncA_r <= 5'h10;
      syncB_r <= 5'h10;
      syncC_r <= 5'h10;
    end else begin
      syncA_r <= {spiSelN, spiSclk, spiMosi, loIn, refIn};
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
    end
  end

  logic refRise;
  logic loRise;
  logic sclkRise;
  logic sclkFall;
  logic selN;
  assign refRise  = syncB_r[0] & ~syncC_r[0];
  assign loRise   = syncB_r[1] & ~syncC_r[1];
  assign sclkRise = syncB_r[3] & ~syncC_r[3];
  assign sclkFall = ~syncB_r[3] & syncC_r[3];
  assign selN     = syncB_r[4];

  // ----------------------------------------------------------------
  // serial port and register file
  // ----------------------------------------------------------------
  lsds_pkg::lsds_spi_e spiState_r;
  lsds_pkg::lsds_spi_e spiState_nxt;
  logic [4:0]  bitCnt_r,   bitCnt_nxt;
  logic [7:0]  shiftIn_r,  shiftIn_nxt;
  logic [7:0]  shiftOut_r, shiftOut_nxt;
  logic [7:0]  cmd_r,      cmd_nxt;
  logic        miso_r,     miso_nxt;
  logic        misoOe_r,   misoOe_nxt;
  logic [7:0]  standby_r,  standby_nxt;
  logic [REF_W-1:0] refDiv_r, refDiv_nxt;
  logic [2:0]  swallow_r,  swallow_nxt;
  logic [CYC_W-1:0] cycles_r, cycles_nxt;
  logic        fastEn_r,   fastEn_nxt;
  logic        pumpInv_r,  pumpInv_nxt;
  logic [2:0]  pumpCode_r, pumpCode_nxt;
  logic [1:0]  testMode_r, testMode_nxt;
  logic [REF_W-1:0] faDiv_r, faDiv_nxt;
  logic [7:0]  readData;
  logic [7:0]  wrByte;

  // byte as it stands once the bit on the pin is shifted in
  assign wrByte = {shiftIn_r[6:0], syncB_r[2]};

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // decoded with the last address bit still on the pin, so data is ready for the first fall
  always_comb begin
    readData = 8'h00;
    if (wrByte[6:0] == lsds_pkg::ADDR_STANDBY) begin
      readData = standby_r;
    end else if (wrByte[6:0] == lsds_pkg::ADDR_REFDIV_H) begin
      readData = {2'h0, refDiv_r[13:8]};
    end else if (wrByte[6:0] == lsds_pkg::ADDR_REFDIV_L) begin
      readData = refDiv_r[7:0];
    end else if (wrByte[6:0] == lsds_pkg::ADDR_SWALLOW) begin
      readData = {swallow_r, cycles_r[12:8]};
    end else if (wrByte[6:0] == lsds_pkg::ADDR_CYCLES_L) begin
      readData = cycles_r[7:0];
    end else if (wrByte[6:0] == lsds_pkg::ADDR_PUMPCTL) begin
      readData = {1'b0, fastEn_r, pumpInv_r, pumpCode_r, testMode_r};
    end else if (wrByte[6:0] == lsds_pkg::ADDR_FADIV_H) begin
      readData = {2'h0, faDiv_r[13:8]};
    end else if (wrByte[6:0] == lsds_pkg::ADDR_FADIV_L) begin
      readData = faDiv_r[7:0];
    end
  end

  always_comb begin
    spiState_nxt = spiState_r;
    bitCnt_nxt   = bitCnt_r;
    shiftIn_nxt  = shiftIn_r;
    shiftOut_nxt = shiftOut_r;
    cmd_nxt      = cmd_r;
    miso_nxt     = miso_r;
    misoOe_nxt   = misoOe_r;
    standby_nxt  = standby_r;
    refDiv_nxt   = refDiv_r;
    swallow_nxt  = swallow_r;
    cycles_nxt   = cycles_r;
    fastEn_nxt   = fastEn_r;
    pumpInv_nxt  = pumpInv_r;
    pumpCode_nxt = pumpCode_r;
    testMode_nxt = testMode_r;
    faDiv_nxt    = faDiv_r;
    if (selN) begin
      spiState_nxt = lsds_pkg::LSDS_SPI_IDLE;
      bitCnt_nxt   = '0;
      misoOe_nxt   = 1'b0;
    end else begin
      case (spiState_r)
        lsds_pkg::LSDS_SPI_IDLE: begin
          spiState_nxt = lsds_pkg::LSDS_SPI_ADDR;
        end
        lsds_pkg::LSDS_SPI_ADDR: begin
          if (sclkRise) begin
            shiftIn_nxt = wrByte;
            bitCnt_nxt  = bitCnt_r + 5'h1;
            if (bitCnt_r == 5'h7) begin
              cmd_nxt      = wrByte;
              spiState_nxt = lsds_pkg::LSDS_SPI_DATA;
            end
          end
        end
        lsds_pkg::LSDS_SPI_DATA: begin
          // first data bit goes out on the falling edge after the command byte
          if (sclkFall && cmd_r[7]) begin
            misoOe_nxt   = 1'b1;
            miso_nxt     = shiftOut_r[7];
            shiftOut_nxt = {shiftOut_r[6:0], 1'b0};
          end
          if (sclkRise) begin
            shiftIn_nxt = wrByte;
            bitCnt_nxt  = bitCnt_r + 5'h1;
            if (bitCnt_r == 5'(lsds_pkg::SPI_BITS - 1)) begin
              spiState_nxt = lsds_pkg::LSDS_SPI_IDLE;
              if (!cmd_r[7]) begin
                if (cmd_r[6:0] == lsds_pkg::ADDR_STANDBY) begin
                  standby_nxt = wrByte;
                  standby_nxt[lsds_pkg::SB_SPARE] = standby_r[lsds_pkg::SB_SPARE];
                end else if (cmd_r[6:0] == lsds_pkg::ADDR_REFDIV_H) begin
                  refDiv_nxt[13:8] = wrByte[5:0];
                end else if (cmd_r[6:0] == lsds_pkg::ADDR_REFDIV_L) begin
                  refDiv_nxt[7:0] = wrByte;
                end else if (cmd_r[6:0] == lsds_pkg::ADDR_SWALLOW) begin
                  swallow_nxt       = wrByte[7:5];
                  cycles_nxt[12:8]  = wrByte[4:0];
                end else if (cmd_r[6:0] == lsds_pkg::ADDR_CYCLES_L) begin
                  cycles_nxt[7:0] = wrByte;
                end else if (cmd_r[6:0] == lsds_pkg::ADDR_PUMPCTL) begin
                  fastEn_nxt   = wrByte[lsds_pkg::PC_FAST];
                  pumpInv_nxt  = wrByte[lsds_pkg::PC_INV];
                  pumpCode_nxt = wrByte[lsds_pkg::PC_CODE_LO +: 3];
                  testMode_nxt = wrByte[lsds_pkg::PC_TM_LO +: 2];
                end else if (cmd_r[6:0] == lsds_pkg::ADDR_FADIV_H) begin
                  faDiv_nxt[13:8] = wrByte[5:0];
                end else if (cmd_r[6:0] == lsds_pkg::ADDR_FADIV_L) begin
                  faDiv_nxt[7:0] = wrByte;
                end
              end
            end
          end
        end
        default: begin
          spiState_nxt = lsds_pkg::LSDS_SPI_IDLE;
        end
      endcase
    end
    if (spiState_r == lsds_pkg::LSDS_SPI_ADDR && sclkRise && bitCnt_r == 5'h7) begin
      shiftOut_nxt = readData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      spiState_r <= lsds_pkg::LSDS_SPI_IDLE;
      bitCnt_r   <= '0;
      shiftIn_r  <= 8'h00;
      shiftOut_r <= 8'h00;
      cmd_r      <= 8'h00;
      miso_r     <= 1'b0;
      misoOe_r   <= 1'b0;
      standby_r  <= lsds_pkg::RST_STANDBY;
      refDiv_r   <= lsds_pkg::RST_REFDIV;
      swallow_r  <= lsds_pkg::RST_SWALLOW;
      cycles_r   <= lsds_pkg::RST_CYCLES;
      fastEn_r   <= 1'b0;
      pumpInv_r  <= 1'b0;
      pumpCode_r <= 3'h0;
      testMode_r <= 2'h0;
      faDiv_r    <= lsds_pkg::RST_FADIV;
    end else begin
      spiState_r <= spiState_nxt;
      bitCnt_r   <= bitCnt_nxt;
      shiftIn_r  <= shiftIn_nxt;
      shiftOut_r <= shiftOut_nxt;
      cmd_r      <= cmd_nxt;
      miso_r     <= miso_nxt;
      misoOe_r   <= misoOe_nxt;
      standby_r  <= standby_nxt;
      refDiv_r   <= refDiv_nxt;
      swallow_r  <= swallow_nxt;
      cycles_r   <= cycles_nxt;
      fastEn_r   <= fastEn_nxt;
      pumpInv_r  <= pumpInv_nxt;
      pumpCode_r <= pumpCode_nxt;
      testMode_r <= testMode_nxt;
      faDiv_r    <= faDiv_nxt;
    end
  end

  assign spiMiso   = miso_r;
  assign spiMisoOe = misoOe_r;

  // ----------------------------------------------------------------
  // dividers
  // ----------------------------------------------------------------
  logic loRun;
  logic refPulse;
  logic faTick;
  logic prePulse;
  logic [CYC_W-1:0] cycCnt_r, cycCnt_nxt;
  logic        fbPulse_r, fbPulse_nxt;
  logic [3:0]  modulus;
  assign loRun = ~standby_r[lsds_pkg::SB_LO] & ~standby_r[lsds_pkg::SB_REF];

  lsds_edge_div #(.W(REF_W)) uRefDiv (
    .clk     (clk),
    .rst     (rst),
    .en      (loRun),
    .tick    (refRise),
    .divisor (refDiv_r),
    .pulse   (refPulse)
  );

  lsds_edge_div #(.W(REF_W)) uFaDiv (
    .clk     (clk),
    .rst     (rst),
    .en      (loRun),
    .tick    (refRise),
    .divisor (faDiv_r),
    .pulse   (faTick)
  );

  assign modulus = (CYC_W'(swallow_r) > cycCnt_r) ? lsds_pkg::PRESC_HIGH
                                                  : lsds_pkg::PRESC_LOW;

  lsds_edge_div #(.W(4)) uPresc (
    .clk     (clk),
    .rst     (rst),
    .en      (loRun),
    .tick    (loRise),
    .divisor (modulus),
    .pulse   (prePulse)
  );

  always_comb begin
    cycCnt_nxt  = cycCnt_r;
    fbPulse_nxt = 1'b0;
    if (!loRun) begin
      cycCnt_nxt = '0;
    end else if (prePulse) begin
      if (cycCnt_r + CYC_W'(1) >= cycles_r) begin
        cycCnt_nxt  = '0;
        fbPulse_nxt = 1'b1;
      end else begin
        cycCnt_nxt = cycCnt_r + CYC_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // phase-frequency detector and pump current
  // ----------------------------------------------------------------
  logic       up_r,    up_nxt;
  logic       down_r,  down_nxt;
  logic [3:0] width_r, width_nxt;
  logic [3:0] steps_r, steps_nxt;
  logic [3:0] nominal;
  logic [3:0] boosted;

  assign nominal = {1'b0, pumpCode_r} + 4'h1;

  always_comb begin
    up_nxt    = up_r;
    down_nxt  = down_r;
    width_nxt = width_r;
    steps_nxt = steps_r;
    boosted   = nominal;
    if (width_r + 4'h1 > boosted) begin
      boosted = width_r + 4'h1;
    end
    if (boosted < lsds_pkg::PUMP_FA_MIN) begin
      boosted = lsds_pkg::PUMP_FA_MIN;
    end
    if (boosted > lsds_pkg::PUMP_MAX) begin
      boosted = lsds_pkg::PUMP_MAX;
    end
    if (!loRun) begin
      up_nxt    = 1'b0;
      down_nxt  = 1'b0;
      width_nxt = '0;
      steps_nxt = nominal;
    end else begin
      // set on edges, clear when both
      if (refPulse) begin
        up_nxt = 1'b1;
      end
      if (fbPulse_r) begin
        down_nxt = 1'b1;
      end
      if (up_nxt && down_nxt) begin
        up_nxt   = 1'b0;
        down_nxt = 1'b0;
      end
      if ((up_r || down_r) && faTick && width_r < lsds_pkg::PUMP_MAX) begin
        width_nxt = width_r + 4'h1;
      end
      if ((up_r || down_r) && !(up_nxt || down_nxt)) begin
        steps_nxt = fastEn_r ? boosted : nominal;
        width_nxt = '0;
      end else if (!(up_r || down_r)) begin
        // hold the boost chosen for the coming pulse unless fast acquire is off
        steps_nxt = fastEn_r ? steps_r : nominal;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cycCnt_r  <= '0;
      fbPulse_r <= 1'b0;
      up_r      <= 1'b0;
      down_r    <= 1'b0;
      width_r   <= '0;
      steps_r   <= 4'h1;
    end else begin
      cycCnt_r  <= cycCnt_nxt;
      fbPulse_r <= fbPulse_nxt;
      up_r      <= up_nxt;
      down_r    <= down_nxt;
      width_r   <= width_nxt;
      steps_r   <= steps_nxt;
    end
  end

  assign pumpUp          = pumpInv_r ? down_r : up_r;
  assign pumpDown        = pumpInv_r ? up_r : down_r;
  assign pumpOutputPinOe = loRun;
  assign pumpSteps       = steps_r;

  // ----------------------------------------------------------------
  // standby effects
  // ----------------------------------------------------------------
  // reference and bias off
  assign refOff               = standby_r[lsds_pkg::SB_REF];
  assign loSynthOff           = standby_r[lsds_pkg::SB_LO];
  assign oscillatorStandby    = standby_r[lsds_pkg::SB_OSC];
  assign samplingSynthStandby = standby_r[lsds_pkg::SB_CKSYN];
  assign gainDacStandby       = standby_r[lsds_pkg::SB_GAIN];
  assign gainDacOe            = ~standby_r[lsds_pkg::SB_GAIN] & ~standby_r[lsds_pkg::SB_REF];
  assign frontEndStandby      = standby_r[lsds_pkg::SB_FRONT];
  assign adcOff               = standby_r[lsds_pkg::SB_ADC];
  assign filterClkRun         = ~standby_r[lsds_pkg::SB_ADC];
  assign digitalHold          = standby_r[lsds_pkg::SB_ADC];
  assign clkBufferOff         = standby_r[lsds_pkg::SB_ADC] & standby_r[lsds_pkg::SB_CKSYN];
  assign mainRefStandby       = &(standby_r | ~lsds_pkg::SB_USED_MASK);

endmodule : lsds_synth_ctrl

// File: lsds_assertions.sv
// checker: standby copies, pump enables and pump current at the top ports
// assumes one clk domain with synchronous active-high rst
`timescale 1ns/1ps
module lsds_assertions (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       pumpUp,
  input wire logic       pumpDown,
  input wire logic       pumpOutputPinOe,
  input wire logic [3:0] pumpSteps,
  input wire logic       refOff,
  input wire logic       loSynthOff,
  input wire logic       oscillatorStandby,
  input wire logic       samplingSynthStandby,
  input wire logic       gainDacStandby,
  input wire logic       gainDacOe,
  input wire logic       frontEndStandby,
  input wire logic       adcOff,
  input wire logic       filterClkRun,
  input wire logic       digitalHold,
  input wire logic       clkBufferOff,
  input wire logic       mainRefStandby
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rstAll;
    $fell(rst) |-> refOff && loSynthOff && adcOff && mainRefStandby;
  endproperty
  a_rstAll: assert property (p_rstAll) else $error("standby not set after reset");
  property p_pinOff;
    (loSynthOff || refOff) |-> !pumpOutputPinOe;
  endproperty
  a_pinOff: assert property (p_pinOff) else $error("pump pin driven in standby");
  // detector needs one edge to clear, so three cycles of standby first
  property p_detClr;
    (loSynthOff || refOff) [*3] |-> !pumpUp && !pumpDown;
  endproperty
  a_detClr: assert property (p_detClr) else $error("pump pulses in standby");
  property p_gain;
    gainDacOe == !(gainDacStandby || refOff);
  endproperty
  a_gain: assert property (p_gain) else $error("gain dac enable wrong");
  property p_adc;
    adcOff |-> digitalHold && !filterClkRun;
  endproperty
  a_adc: assert property (p_adc) else $error("converter standby wrong");
  property p_buf;
    clkBufferOff == (adcOff && samplingSynthStandby);
  endproperty
  a_buf: assert property (p_buf) else $error("clock buffer state wrong");
  property p_main;
    mainRefStandby == (refOff && loSynthOff && oscillatorStandby && samplingSynthStandby
                       && gainDacStandby && frontEndStandby && adcOff);
  endproperty
  a_main: assert property (p_main) else $error("main reference standby wrong");
  property p_steps;
    pumpSteps >= 4'h1 && pumpSteps <= 4'h8;
  endproperty
  a_steps: assert property (p_steps) else $error("pump steps out of range");
  c_awake: cover property (!mainRefStandby);
  c_up: cover property ($rose(pumpUp));
  c_down: cover property ($rose(pumpDown));
  c_max: cover property (pumpSteps == 4'h8);
endmodule : lsds_assertions

bind lsds_synth_ctrl lsds_assertions u_lsds_assertions (
  .clk(clk), .rst(rst), .pumpUp(pumpUp), .pumpDown(pumpDown),
  .pumpOutputPinOe(pumpOutputPinOe), .pumpSteps(pumpSteps), .refOff(refOff),
  .loSynthOff(loSynthOff), .oscillatorStandby(oscillatorStandby),
  .samplingSynthStandby(samplingSynthStandby), .gainDacStandby(gainDacStandby),
  .gainDacOe(gainDacOe), .frontEndStandby(frontEndStandby), .adcOff(adcOff),
  .filterClkRun(filterClkRun), .digitalHold(digitalHold),
  .clkBufferOff(clkBufferOff), .mainRefStandby(mainRefStandby));

// File: lsds_host.sv
// host model: serial port master reaching the control registers
// assumes mode 0 frames, sclk half period of five clk cycles
`timescale 1ns/1ps
module lsds_host (
  input  wire logic clk,
  input  wire logic spiMiso,
  input  wire logic spiMisoOe,
  output logic      spiSclk,
  output logic      spiMosi,
  output logic      spiSelN
);
  initial begin
    spiSclk = 1'b0;
    spiMosi = 1'b0;
    spiSelN = 1'b1;
  end
  task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic [15:0] sh;
    sh = {rw, a, wd};
    rd = 8'h00;
    @(negedge clk);
    spiSelN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spiMosi = sh[i];
      repeat (5) @(negedge clk);
      // a released line reads as unknown so it never matches
      if (i < 8) rd = {rd[6:0], spiMisoOe ? spiMiso : 1'bx};
      spiSclk = 1'b1;
      repeat (5) @(negedge clk);
      spiSclk = 1'b0;
    end
    repeat (5) @(negedge clk);
    spiSelN = 1'b1;
    spiMosi = ~spiMosi;
    repeat (6) @(negedge clk);
  endtask : xfer
endmodule : lsds_host

// File: lsds_tb.sv
// testbench: standby register, dividers and pump current
// assumes the host model owns the serial pins; bench makes ref and lo
`timescale 1ns/1ps
module tb;
  localparam int W = 2000;
  logic       clk, rst, spiSclk, spiMosi, spiSelN, spiMiso, spiMisoOe;
  logic       pumpUp, pumpDown, pumpOutputPinOe;
  logic [3:0] pumpSteps;
  logic [7:0] sb;
  logic [5:0] aux;
  logic [1:0] ph = 2'h0;
  int         num_errors, tests_run;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ref and lo both period four clk, lo a quarter ahead
  always @(negedge clk) ph <= ph + 2'h1;
  lsds_host u_lsds_host (.clk(clk), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe),
    .spiSclk(spiSclk), .spiMosi(spiMosi), .spiSelN(spiSelN));
  lsds_synth_ctrl u_lsds_synth_ctrl (.clk(clk), .rst(rst), .spiSclk(spiSclk),
    .spiMosi(spiMosi), .spiSelN(spiSelN), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe),
    .refIn(ph[1]), .loIn(ph[1] ^ ph[0]), .pumpUp(pumpUp), .pumpDown(pumpDown),
    .pumpOutputPinOe(aux[0]), .pumpSteps(pumpSteps), .refOff(sb[7]),
    .loSynthOff(sb[6]), .oscillatorStandby(sb[5]), .samplingSynthStandby(sb[4]),
    .gainDacStandby(sb[3]), .gainDacOe(aux[5]), .frontEndStandby(sb[2]),
    .adcOff(sb[0]), .filterClkRun(aux[4]), .digitalHold(aux[3]),
    .clkBufferOff(aux[2]), .mainRefStandby(aux[1]));
  assign sb[1] = 1'b1;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    u_lsds_host.xfer(1'b0, a, d, r);
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    u_lsds_host.xfer(1'b1, a, 8'h00, d);
  endtask : rd
  // cycle count at least 3 and above swallow
  task automatic set_div(input logic [13:0] r, input logic [2:0] a, input logic [12:0] b);
    wr(7'h08, {2'h0, r[13:8]});
    wr(7'h09, r[7:0]);
    wr(7'h0a, {a, b[12:8]});
    wr(7'h0b, b[7:0]);
  endtask : set_div
  task automatic count(input logic useUp, input int e);
    logic s, prev;
    int   n;
    prev = 1'b1;
    n = 0;
    repeat (300) @(negedge clk);
    repeat (W) begin
      @(negedge clk);
      s = useUp ? pumpUp : pumpDown;
      if (s === 1'b1 && prev !== 1'b1) n++;
      prev = s;
    end
    chk({7'h0, n >= e - 1 && n <= e + 1}, 8'h01);
  endtask : count
  task automatic t_reset;
    logic [7:0] r;
    rd(7'h00, r);
    chk(r, 8'hff);
    chk({2'h0, aux}, 8'h0e);
    rd(7'h09, r);
    chk(r, lsds_pkg::RST_REFDIV[7:0]);
    rd(7'h0a, r);
    chk(r, {lsds_pkg::RST_SWALLOW, lsds_pkg::RST_CYCLES[12:8]});
    rd(7'h0e, r);
    chk(r, lsds_pkg::RST_FADIV[7:0]);
  endtask : t_reset
  task automatic t_standby;
    logic [7:0] v, r;
    for (int i = 0; i < 10; i++) begin
      v = (i < 8) ? (8'h01 << i) : ((i == 8) ? 8'hfd : 8'h00);
      wr(7'h00, v);
      rd(7'h00, r);
      chk(r, v | 8'h02);
      chk(sb, v | 8'h02);
      chk({2'h0, aux}, {2'h0, ~v[3] & ~v[7], ~v[0], v[0], v[0] & v[4],
          &(v | 8'h02), ~v[6] & ~v[7]});
    end
    // unmapped place: write dropped, reads zero
    wr(7'h05, 8'h5a);
    rd(7'h05, r);
    chk(r, 8'h00);
    rd(7'h00, r);
    chk(r, 8'h02);
  endtask : t_standby
  task automatic t_divide;
    // reference faster than feedback: up rises once per feedback period
    set_div(14'd12, 3'd1, 13'd3);
    count(1'b1, W / (4 * 25));
    set_div(14'd25, 3'd2, 13'd6);
    count(1'b1, W / (4 * 50));
    // feedback faster than reference: down rises once per reference period
    set_div(14'd50, 3'd1, 13'd3);
    count(1'b0, W / (4 * 50));
    // invert bit swaps the pump directions
    wr(7'h0c, 8'h20);
    count(1'b1, W / (4 * 50));
  endtask : t_divide
  task automatic t_pump;
    logic [7:0] r;
    set_div(14'd25, 3'd1, 13'd3);
    for (int c = 0; c < 8; c++) begin
      wr(7'h0c, {3'h0, c[2:0], 2'h0});
      repeat (400) @(negedge clk);
      chk({4'h0, pumpSteps}, {4'h0, 4'(c + 1)});
    end
    // slow feedback gives wide pulses, so the boost must show
    set_div(14'd25, 3'd2, 13'd6);
    wr(7'h0c, 8'h40);
    rd(7'h0c, r);
    chk(r, 8'h40);
    repeat (600) @(negedge clk);
    chk({7'h0, pumpSteps >= 4'h4 && pumpSteps <= 4'h8}, 8'h01);
  endtask : t_pump
  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  initial begin
    rst = 1'b1;
    num_errors = 0;
    tests_run = 0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_standby();
    t_divide();
    t_pump();
    give_verdict();
  end
  // watchdog: the run needs about 23000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
endmodule : tb
